// [verilog/ftl_pkg.sv]
// Package of constants, codes and states for the fault test load sequencer.
package ftl_pkg;

  // ----------------------------------------------------------------------
  // Register map (byte addresses on the register bus)
  // ----------------------------------------------------------------------
  localparam logic [7:0] FTL_CTRL_OFS = 8'h00;
  localparam logic [7:0] FTL_STAT_OFS = 8'h04;
  localparam logic [7:0] FTL_EVT_OFS = 8'h08;
  localparam logic [7:0] FTL_MASK_OFS = 8'h0c;
  localparam logic [7:0] FTL_ADDR_OFS = 8'h10;

  // Reset values and field positions.
  localparam logic FTL_CTRL_EN_RST = 1'b1;
  localparam logic [4:0] FTL_MASK_RST = 5'h00;
  localparam int FTL_NUM_EVT = 5;
  localparam int FTL_EV_RELEASE = 0;
  localparam int FTL_EV_BUF_FULL = 1;
  localparam int FTL_EV_INCORR_LEN = 2;
  localparam int FTL_EV_GAP = 3;
  localparam int FTL_EV_DEV_ERR = 4;

  // ----------------------------------------------------------------------
  // Channel command word layout and codes
  // ----------------------------------------------------------------------
  localparam int FTL_CCW_CMD_LSB = 56;
  localparam int FTL_CCW_ADDR_LSB = 32;
  localparam int FTL_CCW_CDA_BIT = 31;
  localparam int FTL_CCW_CC_BIT = 30;
  localparam logic [3:0] FTL_CMD_TIC = 4'h8;
  localparam logic [23:0] FTL_CCW_STEP = 24'h000008;

  // Forced command word built after initial selection.
  localparam logic [23:0] FTL_FORCED_DATA_ADDR = 24'h000000;
  localparam logic [15:0] FTL_FORCED_COUNT = 16'h0018;
  localparam logic [23:0] FTL_FORCED_CMD_ADDR = 24'h000008;

  // Sequencer states.
  typedef enum logic [2:0] {
    FTL_S_IDLE = 3'b000,
    FTL_S_XFER = 3'b001,
    FTL_S_FETCH = 3'b010,
    FTL_S_WAIT = 3'b011,
    FTL_S_END = 3'b100
  } ftl_state_t;

endpackage

// [verilog/ftl_ccw_decode.sv]
// Field splitter and command classifier for one channel command word.
`timescale 1ns/1ps
module ftl_ccw_decode (
  input wire logic [63:0] ccw,
  output logic [23:0] data_addr,
  output logic [15:0] count,
  output logic chain_data,
  output logic chain_cmd,
  output logic is_tic
);
  import ftl_pkg::*;

  // Plain field extraction; the transfer-in-channel test looks at the low nibble only.
  always_comb begin
    data_addr = ccw[FTL_CCW_ADDR_LSB +: 24];
    count = ccw[15:0];
    chain_data = ccw[FTL_CCW_CDA_BIT];
    chain_cmd = ccw[FTL_CCW_CC_BIT];
    is_tic = (ccw[FTL_CCW_CMD_LSB +: 4] == FTL_CMD_TIC);
  end

endmodule

// [verilog/ftl_event_status.sv]
// Sticky event flags with write-one-to-clear and a per-bit mask.
`timescale 1ns/1ps
module ftl_event_status (
  input wire logic clk,
  input wire logic rst,
  input wire logic [4:0] event_in,
  input wire logic [4:0] clear_in,
  input wire logic [4:0] mask_in,
  output logic [4:0] flags,
  output logic pending
);
  import ftl_pkg::*;

  // ----------------------------------------------------------------------
  // One flag per event
  // ----------------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < FTL_NUM_EVT; i = i + 1) begin : g_flag
      // A set arriving with its clear wins, so no event is ever lost.
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          flags[i] <= 1'b0;
        end else begin
          flags[i] <= event_in[i] | (flags[i] & ~clear_in[i]);
        end
      end
    end
  endgenerate

  // Combined level; the top registers it before it leaves the block.
  assign pending = |(flags & mask_in);

endmodule

// [verilog/ftl_sequencer.sv]
// Fault test load sequencer: processor side, device side, storage port and registers.
//
// Summary of operation
// R1 - Fault test mode input sets the mode latch, which enables the load control.
// R2 - In fault test mode the stop request is blocked, so no logout starts.
// R3 - In fault test mode the controlled or log-wait interrupt is blocked.
// R4 - In fault test mode incorrect length raises no interrupt request.
// R5 - Initial load plus channel select plus unit address start device selection.
// R6 - After selection a forced word reads 24 bytes at 0, chaining to 8.
// R7 - The first record lands as three doublewords at 0, 8 and 16.
// R8 - Chaining fetches the word at 8, which reads the second record to 80h.
// R9 - After the second record, chaining fetches the transfer word at 16.
// R10 - Decoding that transfer word sets the release latch driving release out.
// R11 - The processor drops channel select when it sees release.
// R12 - Channel select dropping after release clears the initial load latch.
// R13 - The transfer word fetches the data-chained read word at 88h for buffer 1.
// R14 - After release, loaded words keep filling buffer 1 and buffer 2 in turn.
// R15 - Each test transfer is watched for errors, incorrect length and gaps.
// R16 - A transfer word decoded with chain data set pulses buffer full.
// R17 - The processor drops fault test mode when loading is complete.
// R18 - Reset clears the mode, load and release latches and all outputs.
`timescale 1ns/1ps
module ftl_sequencer (
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  output logic IRQ,
  input wire logic FAULT_TEST_LOAD_MODE,
  input wire logic INITIAL_PROGRAM_LOAD,
  input wire logic CHANNEL_SELECT,
  input wire logic [7:0] UNIT_ADDR,
  output logic RELEASE,
  output logic BUF_FULL,
  input wire logic LOGOUT_ON_MACHINE_CHECK_SWITCH,
  input wire logic CONTROL_CHECK,
  input wire logic PCI_OR_LOG_WAIT,
  input wire logic INCORRECT_LENGTH,
  output logic STOP_REQ,
  output logic PCI_INTR,
  output logic LEN_INTR_REQ,
  output logic DEV_SELECT,
  output logic [7:0] DEV_UNIT,
  input wire logic DEV_VALID,
  input wire logic [7:0] DEV_DATA,
  input wire logic DEV_END,
  input wire logic DEV_ERR,
  output logic STO_WE,
  output logic STO_RD,
  output logic [23:0] STO_ADDR,
  output logic [7:0] STO_WDATA,
  input wire logic STO_RVALID,
  input wire logic [63:0] STO_RDATA
);
  import ftl_pkg::*;

  ftl_state_t state_ff;
  logic ft_mode_ff, ipl_ff, release_ff, cc_ff, cda_ff, ctrl_en_ff;
  logic [23:0] cmd_addr_ff, data_addr_ff;
  logic [15:0] count_ff;
  logic [4:0] mask_ff, ev_clr, ev_set, ev_flags;
  logic ev_pending, wb_req;
  logic [23:0] dec_addr;
  logic [15:0] dec_count;
  logic dec_cda, dec_cc, dec_tic;
  logic start, tic_fetch, xfer_end, len_short;

  // ----------------------------------------------------------------------
  // Command word decode and event flags
  // ----------------------------------------------------------------------
  ftl_ccw_decode u_dec (
    .ccw(STO_RDATA),
    .data_addr(dec_addr),
    .count(dec_count),
    .chain_data(dec_cda),
    .chain_cmd(dec_cc),
    .is_tic(dec_tic)
  );

  ftl_event_status u_evt (
    .clk(REF_CLK),
    .rst(RST),
    .event_in(ev_set),
    .clear_in(ev_clr),
    .mask_in(mask_ff),
    .flags(ev_flags),
    .pending(ev_pending)
  );

  // Sequence qualifiers shared by the state machine and the flags.
  // R5 start selection
  assign start = (state_ff == FTL_S_IDLE) && ft_mode_ff && ctrl_en_ff &&
                 INITIAL_PROGRAM_LOAD && CHANNEL_SELECT;
  assign tic_fetch = (state_ff == FTL_S_WAIT) && STO_RVALID && dec_tic;
  assign xfer_end = (state_ff == FTL_S_XFER) && ((count_ff == 16'h0000) || DEV_END);
  assign len_short = (state_ff == FTL_S_XFER) && DEV_END && (count_ff != 16'h0000);

  // R15 transfer monitoring
  always_comb begin
    ev_set = 5'h00;
    ev_set[FTL_EV_RELEASE] = tic_fetch && ipl_ff && ft_mode_ff;
    ev_set[FTL_EV_BUF_FULL] = tic_fetch && cda_ff && ft_mode_ff;
    ev_set[FTL_EV_INCORR_LEN] = len_short && ft_mode_ff;
    ev_set[FTL_EV_GAP] = (state_ff == FTL_S_XFER) && DEV_END && ft_mode_ff;
    ev_set[FTL_EV_DEV_ERR] = (state_ff == FTL_S_XFER) && DEV_ERR && ft_mode_ff;
  end

  // ----------------------------------------------------------------------
  // Processor-side latches
  // ----------------------------------------------------------------------
  // R1 mode latch
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      ft_mode_ff <= 1'b0;
    end else begin
      ft_mode_ff <= FAULT_TEST_LOAD_MODE;
    end
  end

  // R18 reset clears latches
  // The load latch stays on from selection until select drops after release or the mode drops.
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      ipl_ff <= 1'b0;
      release_ff <= 1'b0;
    end else begin
      // R12 clear load latch
      if (!ft_mode_ff || (release_ff && !CHANNEL_SELECT)) begin
        ipl_ff <= 1'b0;
        release_ff <= 1'b0;
      end
      if (start) begin
        ipl_ff <= 1'b1;
      end
      // R10 set release latch
      if (tic_fetch && ipl_ff && ft_mode_ff) begin
        release_ff <= 1'b1;
      end
    end
  end

  // Release and buffer full leave the block registered.
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      RELEASE <= 1'b0;
      BUF_FULL <= 1'b0;
    end else begin
      RELEASE <= release_ff;
      // R16 buffer full pulse
      BUF_FULL <= tic_fetch && cda_ff && ft_mode_ff;
    end
  end

  // Ordinary channel paths are gated here so that the test program is never
  // interrupted by a logout or an interrupt routine it cannot service.
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      STOP_REQ <= 1'b0;
      PCI_INTR <= 1'b0;
      LEN_INTR_REQ <= 1'b0;
    end else begin
      // R2 stop suppression
      STOP_REQ <= LOGOUT_ON_MACHINE_CHECK_SWITCH && CONTROL_CHECK && !ft_mode_ff;
      // R3 interrupt suppression
      PCI_INTR <= PCI_OR_LOG_WAIT && !ft_mode_ff;
      // R4 length interrupt block
      LEN_INTR_REQ <= INCORRECT_LENGTH && !ft_mode_ff;
    end
  end

  // ----------------------------------------------------------------------
  // Load sequencer
  // ----------------------------------------------------------------------
  // Dropping the mode abandons any sequence; the processor does this at the end.
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      state_ff <= FTL_S_IDLE;
      cmd_addr_ff <= 24'h000000;
      data_addr_ff <= 24'h000000;
      count_ff <= 16'h0000;
      cc_ff <= 1'b0;
      cda_ff <= 1'b0;
      DEV_SELECT <= 1'b0;
      DEV_UNIT <= 8'h00;
      STO_WE <= 1'b0;
      STO_RD <= 1'b0;
      STO_ADDR <= 24'h000000;
      STO_WDATA <= 8'h00;
    end else begin
      DEV_SELECT <= 1'b0;
      STO_WE <= 1'b0;
      STO_RD <= 1'b0;
      // R17 mode drop frees channel
      if (!ft_mode_ff) begin
        state_ff <= FTL_S_IDLE;
      end else begin
        case (state_ff)
          FTL_S_IDLE: begin
            if (start) begin
              // R6 forced command word
              DEV_SELECT <= 1'b1;
              DEV_UNIT <= UNIT_ADDR;
              data_addr_ff <= FTL_FORCED_DATA_ADDR;
              count_ff <= FTL_FORCED_COUNT;
              cmd_addr_ff <= FTL_FORCED_CMD_ADDR;
              cc_ff <= 1'b1;
              cda_ff <= 1'b0;
              state_ff <= FTL_S_XFER;
            end
          end
          FTL_S_XFER: begin
            if (xfer_end) begin
              // R8 chain to next word
              state_ff <= (cc_ff || cda_ff) ? FTL_S_FETCH : FTL_S_END;
            end else if (DEV_VALID) begin
              // R7 store bytes sequentially
              STO_WE <= 1'b1;
              STO_ADDR <= data_addr_ff;
              STO_WDATA <= DEV_DATA;
              data_addr_ff <= data_addr_ff + 24'h000001;
              count_ff <= count_ff - 16'h0001;
            end
          end
          FTL_S_FETCH: begin
            // R9 fetch at command address
            STO_RD <= 1'b1;
            STO_ADDR <= cmd_addr_ff;
            state_ff <= FTL_S_WAIT;
          end
          FTL_S_WAIT: begin
            if (STO_RVALID) begin
              if (dec_tic) begin
                // R13 branch to target word
                cmd_addr_ff <= dec_addr;
                state_ff <= FTL_S_FETCH;
              end else begin
                // R14 execute loaded word
                cmd_addr_ff <= cmd_addr_ff + FTL_CCW_STEP;
                data_addr_ff <= dec_addr;
                count_ff <= dec_count;
                cc_ff <= dec_cc;
                cda_ff <= dec_cda;
                // Command chaining reselects the device; data chaining stays connected.
                DEV_SELECT <= !cda_ff;
                state_ff <= FTL_S_XFER;
              end
            end
          end
          FTL_S_END: begin
            state_ff <= FTL_S_END;
          end
          default: begin
            state_ff <= FTL_S_IDLE;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // Register bus slave
  // ----------------------------------------------------------------------
  // Ack comes one cycle after the request and drops the cycle after.
  assign wb_req = WB_CYC_I && WB_STB_I && !WB_ACK_O;

  always_comb begin
    ev_clr = 5'h00;
    if (wb_req && WB_WE_I && WB_SEL_I[0] && (WB_ADR_I == FTL_EVT_OFS)) begin
      ev_clr = WB_DAT_I[4:0];
    end
  end

  // Only byte lane 0 carries the narrow control fields.
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      ctrl_en_ff <= FTL_CTRL_EN_RST;
      mask_ff <= FTL_MASK_RST;
    end else if (wb_req && WB_WE_I && WB_SEL_I[0]) begin
      if (WB_ADR_I == FTL_CTRL_OFS) begin
        ctrl_en_ff <= WB_DAT_I[0];
      end
      if (WB_ADR_I == FTL_MASK_OFS) begin
        mask_ff <= WB_DAT_I[4:0];
      end
    end
  end

  // Unmapped addresses are acknowledged and read as zero.
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h00000000;
      IRQ <= 1'b0;
    end else begin
      WB_ACK_O <= wb_req;
      IRQ <= ev_pending;
      if (wb_req && !WB_WE_I) begin
        case (WB_ADR_I)
          FTL_CTRL_OFS: WB_DAT_O <= {31'h00000000, ctrl_en_ff};
          FTL_STAT_OFS: WB_DAT_O <= {24'h000000, cda_ff, cc_ff, release_ff, ipl_ff,
                                     ft_mode_ff, state_ff};
          FTL_EVT_OFS: WB_DAT_O <= {27'h0000000, ev_flags};
          FTL_MASK_OFS: WB_DAT_O <= {27'h0000000, mask_ff};
          FTL_ADDR_OFS: WB_DAT_O <= {8'h00, cmd_addr_ff};
          default: WB_DAT_O <= 32'h00000000;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  sequence tic_cda_s;
    tic_fetch && cda_ff && ft_mode_ff;
  endsequence

  sequence tic_then_fetch_s;
    tic_fetch && ft_mode_ff ##1 (state_ff == FTL_S_FETCH);
  endsequence

  mode_latch_a: assert property (@(posedge REF_CLK) disable iff (RST) // R1
    $rose(FAULT_TEST_LOAD_MODE) |=> ft_mode_ff)
    else $error("Mode latch did not follow the mode input.");

  stop_block_a: assert property (@(posedge REF_CLK) disable iff (RST) // R2
    ft_mode_ff |=> !STOP_REQ)
    else $error("Stop request raised during fault test mode.");

  pci_block_a: assert property (@(posedge REF_CLK) disable iff (RST) // R3
    (ft_mode_ff || !PCI_OR_LOG_WAIT) |=> !PCI_INTR)
    else $error("Controlled interrupt passed during fault test mode.");

  len_block_a: assert property (@(posedge REF_CLK) disable iff (RST) // R4
    (INCORRECT_LENGTH && !ft_mode_ff) |=> LEN_INTR_REQ)
    else $error("Length interrupt lost outside fault test mode.");

  forced_word_a: assert property (@(posedge REF_CLK) disable iff (RST) // R6
    start |=> (state_ff == FTL_S_XFER) && (count_ff == 16'h0018) &&
              (data_addr_ff == 24'h000000) && (cmd_addr_ff == 24'h000008) && DEV_SELECT)
    else $error("Forced command word not set up after selection.");

  byte_store_a: assert property (@(posedge REF_CLK) disable iff (RST) // R7
    (ft_mode_ff && !xfer_end && (state_ff == FTL_S_XFER) && DEV_VALID) |=>
    STO_WE && (STO_ADDR == $past(data_addr_ff)) && (STO_WDATA == $past(DEV_DATA)))
    else $error("Device byte not stored at the data address.");

  release_set_a: assert property (@(posedge REF_CLK) disable iff (RST) // R10
    (tic_fetch && ipl_ff && ft_mode_ff) |=> release_ff ##1 RELEASE)
    else $error("Release not raised after transfer word decode.");

  load_clear_a: assert property (@(posedge REF_CLK) disable iff (RST) // R12
    (release_ff && !CHANNEL_SELECT) |=> !ipl_ff && !release_ff)
    else $error("Load latch not cleared when select dropped.");

  tic_target_a: assert property (@(posedge REF_CLK) disable iff (RST) // R13
    (tic_then_fetch_s and (ft_mode_ff [*2])) |=> STO_RD && (STO_ADDR == $past(dec_addr, 2)))
    else $error("Transfer target word not fetched.");

  buf_full_a: assert property (@(posedge REF_CLK) disable iff (RST) // R16
    tic_cda_s |=> BUF_FULL ##1 !BUF_FULL)
    else $error("Buffer full not a single pulse after data-chained transfer word.");

endmodule

// [verification/ftl_far_model.sv]
// Far-side model of the sequencer: main storage plus a paced byte-stream device.
`timescale 1ns/1ps
module ftl_far_model #(
  parameter int RD_LAT = 1,
  parameter int GAP = 2,
  parameter logic [23:0] BUF1 = 24'h000400,
  parameter logic [23:0] BUF2 = 24'h000480
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic dev_select,
  input wire logic sto_we,
  input wire logic sto_rd,
  input wire logic [23:0] sto_addr,
  input wire logic [7:0] sto_wdata,
  output logic dev_valid,
  output logic [7:0] dev_data,
  output logic sto_rvalid,
  output logic [63:0] sto_rdata
);
  logic [7:0] mem [int];
  logic [7:0] image [$];
  logic [7:0] stream [$];
  logic [31:0] wlog [$];
  logic [23:0] flog [$];
  logic go;
  logic got;
  logic [23:0] fa;

  // Storage is big-endian: the byte at the lowest address is the command byte.
  function automatic logic [63:0] word(input logic [23:0] a);
    logic [63:0] w;
    w = 64'h0;
    for (int i = 0; i < 8; i++) begin
      w = {w[55:0], mem.exists(a + i) ? mem[a + i] : 8'h00};
    end
    return w;
  endfunction

  task automatic put(input logic [63:0] w);
    for (int i = 7; i >= 0; i--) begin
      image.push_back(w[i*8 +: 8]);
    end
  endtask

  // --------------------------------------------------------------------
  // Program image: record 1, record 2 (buffer loop), then test bytes
  // --------------------------------------------------------------------
  // The last buffer gets only three bytes so the channel is left mid-transfer.
  initial begin
    dev_valid = 1'b0;
    dev_data = 8'h00;
    sto_rvalid = 1'b0;
    sto_rdata = 64'h0;
    put(64'h0);
    put({8'h02, 24'h000080, 8'h40, 8'h00, 16'h0028});
    put({8'h08, 24'h000088, 32'h0});
    put({8'h04, 24'h000000, 32'h0});
    put({8'h02, BUF1, 8'h80, 8'h00, 16'h0004});
    put({8'h08, 24'h000098, 32'h0});
    put({8'h02, BUF2, 8'h80, 8'h00, 16'h0004});
    put({8'h08, 24'h000088, 32'h0});
    for (int i = 0; i < 11; i++) begin
      image.push_back(8'ha0 + 8'(i));
    end
    stream = image;
  end

  // The device talks only after it has been selected; reset silences it.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      go <= 1'b0;
    end else if (dev_select === 1'b1) begin
      go <= 1'b1;
    end
  end

  // A byte not stored within three cycles is offered again later, never skipped.
  always begin
    @(posedge clk);
    if (go === 1'b1 && stream.size() > 0) begin
      dev_valid <= 1'b1;
      dev_data <= stream[0];
      @(posedge clk);
      dev_valid <= 1'b0;
      dev_data <= ~stream[0];
      got = 1'b0;
      repeat (3) begin
        @(posedge clk);
        if (sto_we === 1'b1) got = 1'b1;
      end
      if (got) void'(stream.pop_front());
      repeat (GAP) @(posedge clk);
    end
  end

  // Every store is logged as address and data for the bench to judge.
  always @(posedge clk) begin
    if (sto_we === 1'b1) begin
      mem[sto_addr] = sto_wdata;
      wlog.push_back({sto_addr, sto_wdata});
    end
  end

  // Fetches answer after RD_LAT cycles; the bus shows junk outside the answer.
  always begin
    @(posedge clk);
    if (sto_rd === 1'b1) begin
      fa = sto_addr;
      flog.push_back(fa);
      repeat (RD_LAT - 1) @(posedge clk);
      sto_rvalid <= 1'b1;
      sto_rdata <= word(fa);
      @(posedge clk);
      sto_rvalid <= 1'b0;
      sto_rdata <= ~word(fa);
    end
  end
endmodule

// [verification/test_fault_test_load_sequencer.sv]
// Self-checking bench for the fault test load sequencer.
`timescale 1ns/1ps
module test_fault_test_load_sequencer;
  import ftl_pkg::*;
  localparam logic [23:0] BUF1 = 24'h000400;
  localparam logic [23:0] BUF2 = 24'h000480;
  logic ref_clk, rst, cyc, stb, we, ack, irq, mode, initial_program_load, chsel, rel_out, buf_full;
  logic sw, chk_in, pci, inclen, stop_req, pci_intr, len_req, dev_select, dev_valid;
  logic dev_end, dev_err, sto_we, sto_rd, sto_rvalid;
  logic [7:0] adr, unit, dev_unit, dev_data, sto_wdata;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, q;
  logic [23:0] sto_addr;
  logic [63:0] sto_rdata;
  int failures = 0;
  int n_tests = 0;
  int n_buf = 0;

  ftl_sequencer dut_u (.REF_CLK(ref_clk), .RST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat),
    .WB_ACK_O(ack), .IRQ(irq), .FAULT_TEST_LOAD_MODE(mode), .INITIAL_PROGRAM_LOAD(initial_program_load),
    .CHANNEL_SELECT(chsel), .UNIT_ADDR(unit), .RELEASE(rel_out), .BUF_FULL(buf_full),
    .LOGOUT_ON_MACHINE_CHECK_SWITCH(sw), .CONTROL_CHECK(chk_in), .PCI_OR_LOG_WAIT(pci),
    .INCORRECT_LENGTH(inclen), .STOP_REQ(stop_req), .PCI_INTR(pci_intr),
    .LEN_INTR_REQ(len_req), .DEV_SELECT(dev_select), .DEV_UNIT(dev_unit),
    .DEV_VALID(dev_valid), .DEV_DATA(dev_data), .DEV_END(dev_end), .DEV_ERR(dev_err),
    .STO_WE(sto_we), .STO_RD(sto_rd), .STO_ADDR(sto_addr), .STO_WDATA(sto_wdata),
    .STO_RVALID(sto_rvalid), .STO_RDATA(sto_rdata));

  ftl_far_model #(.RD_LAT(3), .GAP(1), .BUF1(BUF1), .BUF2(BUF2)) far_u (.clk(ref_clk),
    .rst(rst), .dev_select(dev_select), .sto_we(sto_we), .sto_rd(sto_rd),
    .sto_addr(sto_addr), .sto_wdata(sto_wdata), .dev_valid(dev_valid),
    .dev_data(dev_data), .sto_rvalid(sto_rvalid), .sto_rdata(sto_rdata));

  // --------------------------------------------------------------------
  // Clock, pulse counting and shared tasks
  // --------------------------------------------------------------------
  always #10 ref_clk = ~ref_clk;

  // Buffer-full pulses are counted so a doubled or missing pulse shows.
  always @(posedge ref_clk) begin
    if (buf_full === 1'b1) n_buf++;
  end

  task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  task report_and_stop;
    if (failures == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Classic single cycle; read data is taken at the edge that sees ack.
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    n = 0;
    @(posedge ref_clk);
    while (ack !== 1'b1 && n < 20) begin
      @(posedge ref_clk);
      n++;
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (n >= 20) failures++;
    @(posedge ref_clk);
  endtask

  // --------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------
  // reset state
  task t_after_reset;
    chk({rel_out, buf_full, stop_req, pci_intr, len_req, dev_select, sto_rd, irq}, 0,
      "idle outputs");
    wb(1'b0, FTL_STAT_OFS, 32'h0);
    chk(q, 32'h0, "status after reset");
    wb(1'b0, FTL_CTRL_OFS, 32'h0);
    chk(q, 32'(FTL_CTRL_EN_RST), "control reset");
    wb(1'b0, FTL_MASK_OFS, 32'h0);
    chk(q, 32'(FTL_MASK_RST), "mask reset");
    wb(1'b0, 8'h3c, 32'h0);
    chk(q, 32'h0, "unmapped read");
  endtask

  task t_block;
    sw <= 1'b1;
    chk_in <= 1'b1;
    pci <= 1'b1;
    inclen <= 1'b1;
    repeat (4) @(posedge ref_clk);
    chk({stop_req, pci_intr, len_req}, 3'b111, "paths open");
    mode <= 1'b1;
    repeat (4) @(posedge ref_clk);
    chk({stop_req, pci_intr, len_req}, 3'b000, "paths blocked");
    wb(1'b0, FTL_STAT_OFS, 32'h0);
    chk(q[3], 1'b1, "mode latch");
  endtask

  task t_load;
    int n;
    logic [23:0] ea;
    logic [23:0] ef [7];
    ef = '{24'h8, 24'h10, 24'h88, 24'h90, 24'h98, 24'ha0, 24'h88};
    unit <= 8'h5a;
    initial_program_load <= 1'b1;
    chsel <= 1'b1;
    n = 0;
    while (dev_select !== 1'b1 && n < 50) begin
      @(posedge ref_clk);
      n++;
    end
    @(posedge ref_clk);
    chk(dev_unit, 8'h5a, "selected unit");
    while (rel_out !== 1'b1 && n < 3000) begin
      @(posedge ref_clk);
      n++;
    end
    chk(rel_out, 1'b1, "release raised");
    chk(far_u.flog[0], 24'h8, "second fetch");
    chk(far_u.flog[1], 24'h10, "transfer word fetch");
    wb(1'b0, FTL_STAT_OFS, 32'h0);
    chk(q[5:4], 2'b11, "load and release latches");
    chsel <= 1'b0;
    initial_program_load <= 1'b0;
    repeat (4) @(posedge ref_clk);
    chk(rel_out, 1'b0, "release dropped");
    wb(1'b0, FTL_STAT_OFS, 32'h0);
    chk(q[5:4], 2'b00, "load latch cleared");
    while (far_u.wlog.size() < 75 && n < 8000) begin
      @(posedge ref_clk);
      n++;
    end
    repeat (10) @(posedge ref_clk);
    for (int k = 0; k < 75; k++) begin
      ea = (k < 24) ? 24'(k) : (k < 64) ? 24'(k + 104) :
        (k < 68) ? BUF1 + 24'(k - 64) : (k < 72) ? BUF2 + 24'(k - 68) : BUF1 + 24'(k - 72);
      chk(far_u.wlog[k], {ea, far_u.image[k]}, "stored byte");
    end
    for (int k = 0; k < 7; k++) begin
      chk(far_u.flog[k], ef[k], "fetch address");
    end
    chk(far_u.flog.size(), 7, "fetch count");
    chk(n_buf, 2, "buffer full pulses");
    chk({stop_req, pci_intr, len_req}, 3'b000, "still blocked");
  endtask

  task t_events;
    wb(1'b0, FTL_EVT_OFS, 32'h0);
    chk(q[1:0], 2'b11, "release and full events");
    chk(irq, 1'b0, "all masked");
    dev_err <= 1'b1;
    @(posedge ref_clk);
    dev_err <= 1'b0;
    dev_end <= 1'b1;
    @(posedge ref_clk);
    dev_end <= 1'b0;
    repeat (3) @(posedge ref_clk);
    wb(1'b0, FTL_EVT_OFS, 32'h0);
    chk(q[4:2], 3'b111, "error, gap and short record events");
    wb(1'b1, FTL_MASK_OFS, 32'h10);
    repeat (3) @(posedge ref_clk);
    chk(irq, 1'b1, "unmasked error");
    wb(1'b1, FTL_EVT_OFS, 32'h10);
    repeat (3) @(posedge ref_clk);
    chk(irq, 1'b0, "error cleared");
  endtask

  // end of load and reset mid-run
  task t_finish;
    mode <= 1'b0;
    repeat (4) @(posedge ref_clk);
    chk({stop_req, pci_intr, len_req}, 3'b111, "paths reopen");
    wb(1'b0, FTL_STAT_OFS, 32'h0);
    chk(q[5:0], 6'h00, "back to idle");
    mode <= 1'b1;
    initial_program_load <= 1'b1;
    chsel <= 1'b1;
    repeat (8) @(posedge ref_clk);
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    chk({rel_out, buf_full, stop_req, pci_intr, len_req, dev_select, sto_we, sto_rd}, 0,
      "outputs in reset");
    rst <= 1'b0;
    repeat (2) @(posedge ref_clk);
  endtask

  // Main sequence: every input has a value at time zero, reset held 12 cycles.
  initial begin
    ref_clk = 1'b0;
    rst = 1'b1;
    {cyc, stb, we, mode, initial_program_load, chsel, sw, chk_in, pci, inclen, dev_end, dev_err} = '0;
    sel = 4'h1;
    adr = 8'h00;
    wdat = 32'h0;
    unit = 8'h00;
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    t_after_reset();
    t_block();
    t_load();
    t_events();
    t_finish();
    report_and_stop();
  end

  // Watchdog: the run needs under a thousand cycles, so 50000 means a hang.
  initial begin
    #1000000;
    failures++;
    report_and_stop();
  end
endmodule
